// *** hw/cmp_event_pkg.sv ***
// Constants shared by the comparator edge-event control block
package cmp_event_pkg;

    // Comparator control register field layout
    localparam int NEG_HYST_LSB = 0;
    localparam int POS_HYST_LSB = 2;
    localparam int HYST_W       = 2;

    // Hysteresis codes: 20 mV, 10 mV, 5 mV, off
    localparam logic [1:0] HYST_20MV = 2'h3;
    localparam logic [1:0] HYST_10MV = 2'h2;
    localparam logic [1:0] HYST_5MV  = 2'h1;
    localparam logic [1:0] HYST_OFF  = 2'h0;

    // Reset values
    localparam logic [3:0] CTRL_HYST_RST = 4'h0;
    localparam logic [1:0] MODE_RST      = 2'h2;
    localparam logic       ENABLE_RST    = 1'h0;

    // Synchroniser depth for the analog output
    localparam int SYNC_STAGES = 2;

endpackage

// *** hw/comparator_edge_event_control.sv ***
// Comparator control, edge capture and interrupt request logic
//
// Behaviour
// - The four-bit hysteresis field sits in bits 3:0 of the control register and software writes it.
// - The negative hysteresis field selects 20 mV, 10 mV, 5 mV or off and drives the analog core.
// - The positive hysteresis field uses the same choices and works independently of the negative one.
// - Software writes a response time selection and slower choices mean lower core supply current.
// - A high-to-low change of the comparator output sets the falling-edge flag.
// - A low-to-high change of the comparator output sets the rising-edge flag.
// - Both edge flags hold once set until software writes them to zero.
// - The rising-edge flag requests an interrupt only while its enable is one.
// - The falling-edge flag requests an interrupt only while its enable is one.
// - A read-only status bit shows the comparator output level two core_clk cycles late, through the synchroniser.
// - The comparator is powered while the enable bit is one and off while it is zero.
// - Spurious edges may be recorded after enabling or after a hysteresis or response change.
module comparator_edge_event_control
    import cmp_event_pkg::*;
#(
    parameter int MODE_W = 2
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // Control register write port
    input  wire logic              ctrl_wr,
    input  wire logic [3:0]        ctrl_hyst_wdata,
    input  wire logic              ctrl_enable_wdata,
    input  wire logic              ctrl_rise_flag_wdata,
    input  wire logic              ctrl_fall_flag_wdata,
    // Mode register write port
    input  wire logic              mode_wr,
    input  wire logic [MODE_W-1:0] mode_wdata,
    input  wire logic              mode_rise_ie_wdata,
    input  wire logic              mode_fall_ie_wdata,
    // Analog comparator output, asynchronous
    input  wire logic              comparator_out,
    // Controls to the analog core
    output logic                   comparator_enable_bit,
    output logic [1:0]             neg_hysteresis_sel,
    output logic [1:0]             pos_hysteresis_sel,
    output logic [MODE_W-1:0]      response_time_sel,
    // Status back to software
    output logic                   comparator_output_state,
    output logic                   rising_edge_flag,
    output logic                   falling_edge_flag,
    output logic                   rising_irq_enable,
    output logic                   falling_irq_enable,
    // Interrupt request
    output logic                   comparator_irq
);

    // Elaboration check: the mode field needs one to four bits
    if (MODE_W < 1 || MODE_W > 4) begin : g_bad_mode_w
        $error("MODE_W must lie between 1 and 4");
    end

    logic [3:0]        hyst_r;
    logic              enable_r;
    logic [MODE_W-1:0] mode_r;
    logic              rise_ie_r;
    logic              fall_ie_r;
    logic              sync1_r;
    logic              sync2_r;
    logic              prev_r;
    logic              rise_flag_r;
    logic              fall_flag_r;
    logic              irq_r;

    logic              rise_edge;
    logic              fall_edge;
    logic              rise_flag_nxt;
    logic              fall_flag_nxt;
    logic              irq_nxt;

    // Edge decode works only on the second synchroniser stage
    assign rise_edge = sync2_r & ~prev_r;
    assign fall_edge = ~sync2_r & prev_r;

    // Set wins over a clear in the same cycle so no edge is lost
    assign rise_flag_nxt = rise_edge |
        (ctrl_wr ? (rise_flag_r & ctrl_rise_flag_wdata) : rise_flag_r);
    assign fall_flag_nxt = fall_edge |
        (ctrl_wr ? (fall_flag_r & ctrl_fall_flag_wdata) : fall_flag_r);

    // Request follows the registered flags and masks
    assign irq_nxt = (rise_flag_r & rise_ie_r)
                   | (fall_flag_r & fall_ie_r);

    // Control register: hysteresis and enable
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hyst_r   <= CTRL_HYST_RST;
            enable_r <= ENABLE_RST;
        end else if (ctrl_wr) begin
            hyst_r   <= ctrl_hyst_wdata;
            enable_r <= ctrl_enable_wdata;
        end
    end

    // Mode register: response time and interrupt masks
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r    <= MODE_W'(MODE_RST);
            rise_ie_r <= 1'h0;
            fall_ie_r <= 1'h0;
        end else if (mode_wr) begin
            mode_r    <= mode_wdata;
            rise_ie_r <= mode_rise_ie_wdata;
            fall_ie_r <= mode_fall_ie_wdata;
        end
    end

    // Two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 1'h0;
            sync2_r <= 1'h0;
            prev_r  <= 1'h0;
        end else begin
            sync1_r <= comparator_out;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Edge flags; core settling after enable can set them falsely
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rise_flag_r <= 1'h0;
            fall_flag_r <= 1'h0;
            irq_r       <= 1'h0;
        end else begin
            rise_flag_r <= rise_flag_nxt;
            fall_flag_r <= fall_flag_nxt;
            irq_r       <= irq_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign comparator_enable_bit   = enable_r;
    assign neg_hysteresis_sel      = hyst_r[NEG_HYST_LSB +: HYST_W];
    assign pos_hysteresis_sel      = hyst_r[POS_HYST_LSB +: HYST_W];
    assign response_time_sel       = mode_r;
    assign comparator_output_state = sync2_r;
    assign rising_edge_flag        = rise_flag_r;
    assign falling_edge_flag       = fall_flag_r;
    assign rising_irq_enable       = rise_ie_r;
    assign falling_irq_enable      = fall_ie_r;
    assign comparator_irq          = irq_r;

endmodule

// *** tb/cmp_core_model.sv ***
// Behavioural analog comparator core facing the control block
module cmp_core_model (
    input  wire logic comparator_enable_bit,
    input  wire logic vin_hi,
    output logic      comparator_out
);
    timeunit 1ns; timeprecision 1ns;
    // An unpowered core makes no decision, so it reads low
    assign comparator_out = comparator_enable_bit & vin_hi;
endmodule

// *** tb/cmp_event_asserts.sv ***
// Port checks for the comparator edge-event control block
module cmp_event_asserts #(parameter int MODE_W = 2) (
    input wire logic core_clk, rstn, ctrl_wr, ctrl_enable_wdata,
    input wire logic ctrl_rise_flag_wdata, mode_wr, comparator_out,
    input wire logic [3:0] ctrl_hyst_wdata,
    input wire logic [MODE_W-1:0] mode_wdata, response_time_sel,
    input wire logic [1:0] neg_hysteresis_sel, pos_hysteresis_sel,
    input wire logic comparator_enable_bit, comparator_output_state,
    input wire logic rising_edge_flag, falling_edge_flag, comparator_irq,
    input wire logic rising_irq_enable, falling_irq_enable
);
    timeunit 1ns; timeprecision 1ns;
    logic [1:0] up_r;
    wire req_w = rising_edge_flag & rising_irq_enable
        | falling_edge_flag & falling_irq_enable;
    // Synchroniser history is only valid two edges after reset
    always_ff @(posedge core_clk or negedge rstn)
        if (!rstn) up_r <= 2'h0; else up_r <= {up_r[0], 1'h1};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_hyst_load: assert property (ctrl_wr |=>
        {pos_hysteresis_sel, neg_hysteresis_sel} == $past(ctrl_hyst_wdata))
        else $error("hyst");
    a_mode_load: assert property (mode_wr |=>
        response_time_sel == $past(mode_wdata)) else $error("mode");
    a_enable_load: assert property (ctrl_wr |=>
        comparator_enable_bit == $past(ctrl_enable_wdata)) else $error("en");
    a_out_sync: assert property (up_r[1] |->
        comparator_output_state == $past(comparator_out, 2)) else $error("out");
    a_rise_set: assert property ($rose(comparator_output_state) |=>
        rising_edge_flag) else $error("rise");
    a_fall_set: assert property ($fell(comparator_output_state) |=>
        falling_edge_flag) else $error("fall");
    a_flag_sticky: assert property (rising_edge_flag &&
        !(ctrl_wr && !ctrl_rise_flag_wdata) |=> rising_edge_flag) else $error("hold");
    a_irq_mask: assert property (up_r[0] |->
        comparator_irq == $past(req_w)) else $error("irq");
    c_rise: cover property ($rose(rising_edge_flag));
    c_fall: cover property ($rose(falling_edge_flag));
    c_irq: cover property ($rose(comparator_irq));
endmodule
bind comparator_edge_event_control cmp_event_asserts #(.MODE_W(MODE_W)) chk_u (.*);

// *** tb/tb_top.sv ***
// Self-checking bench for the comparator edge-event control block
module tb_top;
    timeunit 1ns; timeprecision 1ns;
    logic core_clk = 0, rstn = 0, ctrl_wr = 0, ctrl_enable_wdata = 0;
    logic ctrl_rise_flag_wdata = 1, ctrl_fall_flag_wdata = 1, vin_hi = 0;
    logic mode_wr = 0, mode_rise_ie_wdata = 0, mode_fall_ie_wdata = 0;
    logic [3:0] ctrl_hyst_wdata = 4'h0;
    logic [1:0] mode_wdata = 2'h0, response_time_sel;
    logic [1:0] neg_hysteresis_sel, pos_hysteresis_sel;
    logic comparator_out, comparator_enable_bit, comparator_output_state;
    logic rising_edge_flag, falling_edge_flag, rising_irq_enable;
    logic falling_irq_enable, comparator_irq;
    int n_errors = 0, checked = 0, cyc = 0;
    wire [3:0] hs = {pos_hysteresis_sel, neg_hysteresis_sel};
    comparator_edge_event_control dut_u (.*);
    cmp_core_model core_u (.*);
    initial forever #20 core_clk = ~core_clk;
    // Whole run is well under a hundred cycles, so this only cuts a hang
    always @(posedge core_clk) if (++cyc == 500) begin
        n_errors++;
        complete_run;
    end
    task automatic chk(string nm, logic [3:0] e, g);
        checked++;
        if (g !== e) begin n_errors++; $display("BAD %s %h %h", nm, e, g); end
    endtask
    task automatic wr_ctrl(logic [3:0] h, logic e, r, f);
        @(posedge core_clk) #1 {ctrl_wr, ctrl_hyst_wdata} = {1'h1, h};
        {ctrl_enable_wdata, ctrl_rise_flag_wdata, ctrl_fall_flag_wdata} = {e, r, f};
        @(posedge core_clk) #1 ctrl_wr = 0;
    endtask
    task automatic wr_mode(logic [1:0] m, logic r, f);
        @(posedge core_clk) #1 {mode_wr, mode_wdata} = {1'h1, m};
        {mode_rise_ie_wdata, mode_fall_ie_wdata} = {r, f};
        @(posedge core_clk) #1 mode_wr = 0;
    endtask
    task automatic tick(int n); repeat (n) @(posedge core_clk); #1; endtask
    task automatic complete_run;
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Settings first, then one rising and one falling event with masks
    initial begin
        repeat (3) @(posedge core_clk);
        #1 rstn = 1;
        chk("resp", cmp_event_pkg::MODE_RST, response_time_sel);
        for (int i = 0; i < 4; i++) begin
            wr_ctrl({~i[1:0], i[1:0]}, 1, 1, 1);
            chk("hyst", {~i[1:0], i[1:0]}, hs);
            wr_mode(i[1:0], 0, 0);
            chk("resp", i[3:0], response_time_sel);
        end
        chk("en", 1, comparator_enable_bit);
        wr_ctrl(4'h3, 1, 0, 0);
        vin_hi = 1;
        tick(4);
        chk("out", 1, comparator_output_state);
        chk("rise", 1, rising_edge_flag);
        chk("irq", 0, comparator_irq);
        wr_mode(2'h2, 1, 0);
        chk("rie", 1, rising_irq_enable);
        chk("fie", 0, falling_irq_enable);
        tick(1);
        chk("irq", 1, comparator_irq);
        vin_hi = 0;
        tick(4);
        chk("fall", 1, falling_edge_flag);
        chk("rise", 1, rising_edge_flag);
        wr_ctrl(4'h3, 0, 0, 1);
        chk("rise", 0, rising_edge_flag);
        chk("fall", 1, falling_edge_flag);
        tick(1);
        chk("irq", 0, comparator_irq);
        wr_mode(2'h2, 0, 1);
        chk("fie", 1, falling_irq_enable);
        chk("rie", 0, rising_irq_enable);
        tick(1);
        chk("irq", 1, comparator_irq);
        chk("en", 0, comparator_enable_bit);
        complete_run;
    end
endmodule
